// file: rtl/sfe_dev.sv
// Device end of the serial flash front end: link decode, status, program and erase.
// Assumes link pins are asynchronous to mclk and slow enough to be oversampled.
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "sfe_defs.svh"
module sfe_dev #(
	parameter int ADDR_W = 21 // Byte address width, 13 to 24
) (
	input  wire logic mclk,    // System clock
	input  wire logic rst,     // Synchronous reset
	sfe_if.dev        pins,    // Link pins
	output logic      busy,    // Internal cycle running
	output logic      standby  // Deselected and idle
);
	import sfe_pkg::*;

	localparam int SW = ADDR_W - `SFE_SECT_BITS;

	typedef struct packed {
		logic [4:0]        y1;
		logic [4:0]        y2;
		logic [4:0]        y3;
		logic              sel;
		logic              lock;
		logic              hold;
		logic [2:0]        bitc;
		logic [2:0]        bytec;
		logic [7:0]        sh;
		logic [7:0]        op;
		logic [23:0]       addr;
		logic              tx_on;
		logic [7:0]        tx_sh;
		logic [2:0]        tx_bits;
		logic              miso;
		logic              oe;
		logic              wlatch;
		logic              lockb;
		logic [2:0]        prot;
		logic [7:0]        sr_new;
		logic [255:0]      pvld;
		sfe_job_t          job;
		logic [ADDR_W-1:0] cnt;
		logic [ADDR_W-1:0] lim;
		logic [ADDR_W-1:0] base;
		logic              busy;
		logic              standby;
	} sfe_dev_st_t;

	sfe_dev_st_t       q;
	sfe_dev_st_t       n;
	logic [7:0]        mem [0:(1<<ADDR_W)-1];
	logic [7:0]        pbuf [0:255];
	logic              mem_we;
	logic [ADDR_W-1:0] mem_wa;
	logic [7:0]        mem_wd;
	logic              pb_we;
	logic [7:0]        pb_wa;
	logic [7:0]        pb_wd;
	logic [7:0]        byte_in;
	logic [23:0]       a_new;
	logic              rise;
	logic              fall;
	logic              cs_fall;
	logic              cs_rise;
	logic [4:0]        sect;

	// Protected when the sector lies in the upper part chosen by the level
	function automatic logic is_prot(input logic [4:0] s, input logic [2:0] lvl);
		logic [5:0] thr;
		thr = `SFE_SECT_ALL - (6'h01 << (lvl - 3'h1));
		if (lvl == 3'h0)
			return 1'b0;
		if (lvl[2] & lvl[1])
			return 1'b1;
		return {1'b0, s} >= thr;
	endfunction

	function automatic logic [7:0] status(input sfe_dev_st_t s);
		logic [7:0] r;
		r = `SFE_ST_RST;
		r[`SFE_ST_BUSY] = (s.job != sfe_job_idle);
		r[`SFE_ST_WLATCH] = s.wlatch;
		r[`SFE_ST_PROT] = s.prot;
		r[`SFE_ST_LOCK] = s.lockb;
		return r;
	endfunction

	always_comb begin
		n = q;
		mem_we = 1'b0;
		mem_wa = '0;
		mem_wd = 8'h00;
		pb_we = 1'b0;
		pb_wa = 8'h00;
		pb_wd = 8'h00;
		n.y1 = {pins.wp_n, pins.hold_n, pins.mosi, pins.cs_n, pins.sclk};
		n.y2 = q.y1;
		n.y3 = q.y2;
		byte_in = {q.sh[6:0], q.y2[`SFE_I_MOSI]};
		a_new = {q.addr[15:0], byte_in};
		sect = q.addr[ADDR_W-1 -: `SFE_SECT_BITS];
		rise = q.y2[`SFE_I_SCLK] & ~q.y3[`SFE_I_SCLK] & q.sel & ~q.hold;
		fall = ~q.y2[`SFE_I_SCLK] & q.y3[`SFE_I_SCLK] & q.sel & ~q.hold;
		cs_fall = ~q.y2[`SFE_I_CS] & q.y3[`SFE_I_CS];
		cs_rise = q.y2[`SFE_I_CS] & ~q.y3[`SFE_I_CS];
		// pause follows pin only while clock low
		if (~q.y2[`SFE_I_SCLK])
			n.hold = q.sel & ~q.y2[`SFE_I_HOLD];
		// sample on rising edge, mode 0 or 3 alike
		if (rise) begin
			n.bitc = q.bitc + 3'h1;
			n.sh = byte_in;
			if (q.bitc == `SFE_BIT_LAST) begin
				if (q.bytec != `SFE_BY_DN)
					n.bytec = q.bytec + 3'h1;
				if (q.bytec == `SFE_BY_OP) begin
					n.op = byte_in;
					if (byte_in == `SFE_OP_RDSTAT) begin
						n.tx_on = 1'b1;
						n.tx_sh = status(q);
					end
					if (byte_in == `SFE_OP_PAGE && q.job == sfe_job_idle)
						n.pvld = '0;
				end else if (q.bytec <= `SFE_BY_A3) begin
					n.addr = a_new;
					if (q.bytec == `SFE_BY_A1)
						n.sr_new = byte_in;
					if (q.bytec == `SFE_BY_A3 && q.op == `SFE_OP_READ && q.job == sfe_job_idle) begin
						n.tx_on = 1'b1;
						n.tx_sh = mem[a_new[ADDR_W-1:0]];
						n.addr = a_new + 24'h1;
					end
				end else if (q.op == `SFE_OP_PAGE && q.job == sfe_job_idle) begin
					pb_we = 1'b1;
					pb_wa = q.addr[7:0];
					pb_wd = byte_in;
					n.pvld[q.addr[7:0]] = 1'b1;
					n.addr[7:0] = q.addr[7:0] + 8'h01;
				end
			end
		end
		if (fall && q.tx_on) begin
			n.miso = q.tx_sh[7];
			n.tx_sh = {q.tx_sh[6:0], 1'b0};
			n.tx_bits = q.tx_bits + 3'h1;
			if (q.tx_bits == `SFE_BIT_LAST) begin
				if (q.op == `SFE_OP_RDSTAT) begin
					n.tx_sh = status(q);
				end else begin
					n.tx_sh = mem[q.addr[ADDR_W-1:0]];
					n.addr = q.addr + 24'h1;
				end
			end
		end
		if (cs_fall) begin
			n.bitc = 3'h0;
			n.bytec = `SFE_BY_OP;
			n.tx_on = 1'b0;
			n.tx_bits = 3'h0;
			// only a falling select opens the link
			if (q.y2[`SFE_I_HOLD] | ~q.lock) begin
				n.sel = 1'b1;
				n.lock = 1'b0;
			end
		end
		if (cs_rise) begin
			n.sel = 1'b0;
			n.hold = 1'b0;
			n.tx_on = 1'b0;
			if (q.hold) begin
				n.lock = 1'b1;
			end else if (q.sel && q.job == sfe_job_idle && q.bitc == 3'h0) begin
				n.cnt = '0;
				if (q.op == `SFE_OP_UNLOCK && q.bytec == `SFE_BY_A1)
					n.wlatch = 1'b1;
				if (q.wlatch) begin
					case (q.op)
						`SFE_OP_PAGE: begin
							if (q.bytec == `SFE_BY_DN && !is_prot(sect, q.prot)) begin
								n.job = sfe_job_prog;
								n.base = {q.addr[ADDR_W-1:8], 8'h00};
								n.lim = ADDR_W'(`SFE_PAGE_LAST);
								n.wlatch = 1'b0;
							end
						end
						`SFE_OP_SECT: begin
							if (q.bytec == `SFE_BY_D0 && !is_prot(sect, q.prot)) begin
								n.job = sfe_job_erase;
								n.base = {sect, {SW{1'b0}}};
								n.lim = {{`SFE_SECT_BITS{1'b0}}, {SW{1'b1}}};
								n.wlatch = 1'b0;
							end
						end
						`SFE_OP_FULL: begin
							if (q.bytec == `SFE_BY_A1 && q.prot == 3'h0) begin
								n.job = sfe_job_erase;
								n.base = '0;
								n.lim = '1;
								n.wlatch = 1'b0;
							end
						end
						`SFE_OP_STW: begin
							if (q.bytec == `SFE_BY_A2) begin
								n.wlatch = 1'b0;
								// protect pin freezes level when locked
								if (!(q.lockb & ~q.y2[`SFE_I_WP])) begin
									n.prot = q.sr_new[`SFE_ST_PROT];
									n.lockb = q.sr_new[`SFE_ST_LOCK];
									n.job = sfe_job_stat;
									n.lim = ADDR_W'(`SFE_STW_CYC - 1);
								end
							end
						end
						default: ;
					endcase
				end
			end
		end
		// flat byte array, sectors are top address bits
		mem_wa = q.base + q.cnt;
		case (q.job)
			sfe_job_prog: begin
				mem_we = q.pvld[q.cnt[7:0]];
				mem_wd = mem[mem_wa] & pbuf[q.cnt[7:0]];
			end
			sfe_job_erase: begin
				mem_we = 1'b1;
				mem_wd = 8'hff;
			end
			default: ;
		endcase
		if (q.job != sfe_job_idle) begin
			if (q.cnt == q.lim)
				n.job = sfe_job_idle;
			else
				n.cnt = q.cnt + ADDR_W'(1);
		end
		// drive only while selected and not paused
		n.oe = n.sel & ~n.hold;
		n.busy = (n.job != sfe_job_idle);
		// standby waits for internal cycle end
		// Next job state, so standby never overlaps the first busy cycle
		n.standby = q.y2[`SFE_I_CS] & (n.job == sfe_job_idle);
	end

	always_ff @(posedge mclk) begin
		if (rst)
			q <= '0;
		else
			q <= n;
	end

	// Array has no reset: contents are undefined until erased
	always_ff @(posedge mclk) begin
		if (mem_we)
			mem[mem_wa] <= mem_wd;
		if (pb_we)
			pbuf[pb_wa] <= pb_wd;
	end

	assign pins.miso_o = q.miso;
	assign pins.miso_oe = q.oe;
	assign busy = q.busy;
	assign standby = q.standby;
endmodule

// file: rtl/sfe_defs.svh
// Constants of the serial flash front end: opcodes, status layout, counts, host map.
// Assumes inclusion by bare name from the device end, the master end and the bench.
`ifndef SFE_DEFS_SVH
`define SFE_DEFS_SVH
`define SFE_OP_UNLOCK   8'h06
`define SFE_OP_PAGE     8'h02
`define SFE_OP_SECT     8'hd8
`define SFE_OP_FULL     8'hc7
`define SFE_OP_STW      8'h01
`define SFE_OP_RDSTAT   8'h05
`define SFE_OP_READ     8'h03
`define SFE_ST_BUSY     0
`define SFE_ST_WLATCH   1
`define SFE_ST_PROT     4:2
`define SFE_ST_LOCK     7
`define SFE_ST_RST      8'h00
`define SFE_STW_CYC     16
`define SFE_PAGE_LAST   8'hff
`define SFE_SECT_BITS   5
`define SFE_SECT_ALL    6'h20
`define SFE_I_SCLK      0
`define SFE_I_CS        1
`define SFE_I_MOSI      2
`define SFE_I_HOLD      3
`define SFE_I_WP        4
`define SFE_BIT_LAST    3'h7
`define SFE_BY_OP       3'h0
`define SFE_BY_A1       3'h1
`define SFE_BY_A2       3'h2
`define SFE_BY_A3       3'h3
`define SFE_BY_D0       3'h4
`define SFE_BY_DN       3'h5
`define SFE_H_CTRL      4'h0
`define SFE_H_TX        4'h4
`define SFE_H_RX        4'h8
`define SFE_H_STAT      4'hc
`define SFE_C_CS        0
`define SFE_C_HOLD      1
`define SFE_C_WP        2
`define SFE_C_CPOL      3
`define SFE_C_RST       4'h4
`endif

// file: rtl/sfe_pkg.sv
// Types shared by both ends of the serial flash front end.
// Assumes nothing of its surroundings.
package sfe_pkg;
	typedef enum logic [1:0] {sfe_job_idle, sfe_job_prog, sfe_job_erase, sfe_job_stat} sfe_job_t;
	typedef enum logic [1:0] {sfe_h_idle, sfe_h_low, sfe_h_high} sfe_hst_t;
endpackage

// file: rtl/sfe_if.sv
// Serial link between flash device end and master end.
// Assumes a pull-up on the data-out wire, so an undriven wire reads high.
`timescale 1ns/1ps
interface sfe_if;
	logic sclk;    // Serial clock
	logic cs_n;    // Chip select
	logic mosi;    // Data into the device
	logic miso_o;  // Device data out
	logic miso_oe; // Device drives data out
	logic hold_n;  // Pause
	logic wp_n;    // Write protect
	logic miso;    // Resolved data-out wire
	assign miso = miso_oe ? miso_o : 1'b1;
	modport dev  (input sclk, cs_n, mosi, hold_n, wp_n, output miso_o, miso_oe);
	modport host (output sclk, cs_n, mosi, hold_n, wp_n, input miso);
endinterface

// file: rtl/sfe_host.sv
// Master end of the serial flash front end: byte shifter behind a small register port.
// Assumes software sequences select, bytes and deselect; one byte per TX write.
`timescale 1ns/1ps
`include "sfe_defs.svh"
module sfe_host #(
	parameter int HALF = 8 // mclk cycles per serial clock half period
) (
	input  wire logic       mclk,  // System clock
	input  wire logic       rst,   // Synchronous reset
	sfe_if.host             pins,  // Link pins
	input  wire logic [3:0] addr,  // Register byte address
	input  wire logic [7:0] wdata, // Write data
	input  wire logic       wr,    // Write strobe
	input  wire logic       rd,    // Read strobe
	output logic      [7:0] rdata  // Read data, cycle after rd
);
	import sfe_pkg::*;

	localparam int DW = $clog2(HALF) + 1;

	typedef struct packed {
		logic [3:0]    ctrl;
		logic          m1;
		logic          m2;
		logic          sclk;
		logic          cs_n;
		logic          mosi;
		logic          hold_n;
		logic          wp_n;
		logic [7:0]    tx;
		logic [7:0]    rx;
		logic [2:0]    bits;
		logic [DW-1:0] div;
		sfe_hst_t      st;
		logic [7:0]    rdata;
	} sfe_host_st_t;

	sfe_host_st_t q;
	sfe_host_st_t n;

	always_comb begin
		n = q;
		n.m1 = pins.miso;
		n.m2 = q.m1;
		n.rdata = 8'h00;
		if (wr && addr == `SFE_H_CTRL)
			n.ctrl = wdata[3:0];
		if (rd) begin
			case (addr)
				`SFE_H_CTRL: n.rdata = {4'h0, q.ctrl};
				`SFE_H_TX:   n.rdata = q.tx;
				`SFE_H_RX:   n.rdata = q.rx;
				`SFE_H_STAT: n.rdata = {7'h00, q.st != sfe_h_idle};
				default:     n.rdata = 8'h00;
			endcase
		end
		n.wp_n = q.ctrl[`SFE_C_WP];
		n.hold_n = ~(q.ctrl[`SFE_C_HOLD] & ~q.cs_n);
		case (q.st)
			sfe_h_idle: begin
				n.sclk = q.ctrl[`SFE_C_CPOL];
				n.cs_n = ~q.ctrl[`SFE_C_CS];
				if (wr && addr == `SFE_H_TX) begin
					n.tx = wdata;
					n.sclk = 1'b0;
					n.mosi = wdata[7];
					n.bits = 3'h0;
					n.div = '0;
					n.st = sfe_h_low;
				end
			end
			sfe_h_low: begin
				// Stall while paused so no bit is lost
				if (q.hold_n) begin
					n.div = q.div + DW'(1);
					if (q.div == DW'(HALF - 1)) begin
						n.sclk = 1'b1;
						n.div = '0;
						n.st = sfe_h_high;
					end
				end
			end
			sfe_h_high: begin
				if (q.hold_n) begin
					n.div = q.div + DW'(1);
					if (q.div == DW'(HALF - 1)) begin
						// Late sample: device output settled during high phase
						n.rx = {q.rx[6:0], q.m2};
						n.div = '0;
						if (q.bits == `SFE_BIT_LAST) begin
							n.sclk = q.ctrl[`SFE_C_CPOL];
							n.st = sfe_h_idle;
						end else begin
							n.sclk = 1'b0;
							n.bits = q.bits + 3'h1;
							n.tx = {q.tx[6:0], 1'b0};
							n.mosi = q.tx[6];
							n.st = sfe_h_low;
						end
					end
				end
			end
			default: n.st = sfe_h_idle;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			q <= '0;
			q.ctrl <= `SFE_C_RST;
			q.cs_n <= 1'b1;
			q.hold_n <= 1'b1;
			q.wp_n <= 1'b1;
			q.m1 <= 1'b1;
			q.m2 <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign pins.sclk = q.sclk;
	assign pins.cs_n = q.cs_n;
	assign pins.mosi = q.mosi;
	assign pins.hold_n = q.hold_n;
	assign pins.wp_n = q.wp_n;
	assign rdata = q.rdata;
endmodule

// file: tb/sfe_properties.sv
// Concurrent checks on the link that joins the master end and the device end.
// Assumes tb_top instantiates it beside the interface, with the device status outputs.
`timescale 1ns/1ps
module sfe_properties (
	input wire logic mclk,    // System clock
	input wire logic rst,     // Synchronous reset
	input wire logic sclk,    // Serial clock
	input wire logic cs_n,    // Select, active low
	input wire logic mosi,    // Data into device
	input wire logic miso_o,  // Device data out
	input wire logic miso_oe, // Device drives data out
	input wire logic hold_n,  // Pause, active low
	input wire logic wp_n,    // Write protect, active low
	input wire logic busy,    // Device cycle running
	input wire logic standby  // Device idle and deselected
);
	logic [13:0] bcnt_q;
	logic [13:0] bcnt_d;

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	// Longest cycle is a full clear of the reduced array, plus margin
	always_comb bcnt_d = busy ? bcnt_q + 14'h1 : 14'h0;
	always_ff @(posedge mclk) bcnt_q <= rst ? 14'h0 : bcnt_d;

	desel_quiet_a: assert property (cs_n [*5] |-> !miso_oe)
		else $error("data out driven while deselected");
	out_edge_a: assert property (miso_oe && $past(miso_oe) && $changed(miso_o) |-> !sclk)
		else $error("data out changed while serial clock high");
	in_stable_a: assert property (sclk && !cs_n |-> $stable(mosi))
		else $error("data in changed while serial clock high");
	idle_standby_a: assert property (busy |-> !standby)
		else $error("standby during an internal cycle");
	sel_active_a: assert property (!cs_n [*5] |-> !standby)
		else $error("standby while selected");
	pause_quiet_a: assert property ((!hold_n && !sclk && !cs_n) [*5] |-> !miso_oe)
		else $error("data out driven during pause");
	pause_sel_a: assert property ($fell(hold_n) |-> !cs_n)
		else $error("pause started while deselected");
	busy_start_a: assert property ($rose(busy) |-> cs_n ##1 busy [*7])
		else $error("cycle started while selected or ended early");
	busy_bound_a: assert property (bcnt_q < 14'h2080)
		else $error("internal cycle too long");

	cover property ($rose(busy));
	cover property ((!hold_n && !sclk && !cs_n) [*5]);
	cover property (!wp_n && !cs_n);
	cover property ($rose(standby));
endmodule

// file: tb/tb_top.sv
// Self-checking bench: master end and device end joined by one link.
// Assumes software-style access to the master end over its plain register port.
`timescale 1ns/1ps
`include "sfe_defs.svh"
module tb_top;
	import sfe_pkg::*;
	logic       mclk        = 1'b0;
	logic       rst         = 1'b1;
	logic [3:0] addr        = 4'h0;
	logic [7:0] wdata       = 8'h00;
	logic       wr          = 1'b0;
	logic       rd          = 1'b0;
	logic [7:0] rdata;
	logic       busy;
	logic       standby;
	logic [3:0] ctl         = 4'h4;
	logic [7:0] q_out [$];
	logic [7:0] mem_m [int];
	int         failures    = 0;
	int         comparisons = 0;
	int         seed        = 40546;
	int         cyc         = 0;

	sfe_if link ();
	sfe_host #(.HALF(8)) sfe_host_i (.mclk(mclk), .rst(rst), .pins(link.host), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	sfe_dev #(.ADDR_W(13)) sfe_dev_i (.mclk(mclk), .rst(rst), .pins(link.dev), .busy(busy),
		.standby(standby));
	sfe_properties sfe_properties_i (.mclk(mclk), .rst(rst), .sclk(link.sclk),
		.cs_n(link.cs_n), .mosi(link.mosi), .miso_o(link.miso_o), .miso_oe(link.miso_oe),
		.hold_n(link.hold_n), .wp_n(link.wp_n), .busy(busy), .standby(standby));

	always #5 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			failures++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Model array: unwritten bytes read as erased after the first full clear
	function automatic logic [7:0] ex(input int a);
		return mem_m.exists(a) ? mem_m[a] : 8'hff;
	endfunction
	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [3:0] a, output logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic xfer(input logic [7:0] b, output logic [7:0] r);
		logic [7:0] s;
		int         n;
		wreg(`SFE_H_TX, b);
		n = 0;
		do begin
			rreg(`SFE_H_STAT, s);
			n++;
		end while (s[0] !== 1'b0 && n < 100);
		if (s[0] !== 1'b0)
			failures++;
		rreg(`SFE_H_RX, r);
	endtask
	// Pause is inserted before byte p; a negative p means none
	task automatic frame(input logic [7:0] q [$], input int p = -1);
		logic [7:0] r;
		q_out = {};
		wreg(`SFE_H_CTRL, {4'h0, ctl | 4'h1});
		foreach (q[i]) begin
			if (i == p) begin
				wreg(`SFE_H_CTRL, {4'h0, ctl | 4'h3});
				repeat (40) @(posedge mclk);
				wreg(`SFE_H_CTRL, {4'h0, ctl | 4'h1});
			end
			xfer(q[i], r);
			q_out.push_back(r);
		end
		wreg(`SFE_H_CTRL, {4'h0, ctl});
		repeat (6) @(posedge mclk);
	endtask
	task automatic stat(output logic [7:0] s);
		frame('{`SFE_OP_RDSTAT, 8'h00});
		s = q_out[1];
	endtask
	task automatic wcmd(input logic [7:0] q [$]);
		logic [7:0] s;
		int         n;
		frame('{`SFE_OP_UNLOCK});
		frame(q);
		n = 0;
		do begin
			stat(s);
			n++;
		end while (s[0] !== 1'b0 && n < 200);
		if (s[0] !== 1'b0)
			failures++;
	endtask
	task automatic prog(input int a, input logic [7:0] d [$]);
		logic [7:0] q [$];
		int         j;
		q = '{`SFE_OP_PAGE, 8'h00, a[15:8], a[7:0]};
		foreach (d[i]) begin
			j = (a & 32'h1f00) | ((a + i) & 32'hff);
			q.push_back(d[i]);
			mem_m[j] = ex(j) & d[i];
		end
		wcmd(q);
	endtask
	task automatic rdchk(input int a, input int n, input int p = -1);
		logic [7:0] q [$];
		q = '{`SFE_OP_READ, 8'h00, a[15:8], a[7:0]};
		repeat (n) q.push_back(8'h00);
		frame(q, p);
		for (int i = 0; i < n; i++) chk(q_out[4 + i], ex(a + i));
	endtask

	initial begin
		logic [7:0] s;
		logic [7:0] d [$];
		int         a;
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		repeat (8) @(posedge mclk);
		chk({7'h00, standby}, 8'h01);
		frame('{`SFE_OP_FULL});
		stat(s);
		chk(s, 8'h00);
		// Deselect while paused must drop the unlock just sent
		wreg(`SFE_H_CTRL, {4'h0, ctl | 4'h1});
		xfer(`SFE_OP_UNLOCK, s);
		wreg(`SFE_H_CTRL, {4'h0, ctl | 4'h3});
		repeat (20) @(posedge mclk);
		wreg(`SFE_H_CTRL, {4'h0, ctl | 4'h2});
		repeat (20) @(posedge mclk);
		wreg(`SFE_H_CTRL, {4'h0, ctl});
		stat(s);
		chk(s, 8'h00);
		$display("test pause deselect done");
		frame('{`SFE_OP_UNLOCK});
		frame('{`SFE_OP_FULL});
		stat(s);
		chk(s, 8'h01);
		chk({7'h00, standby}, 8'h00);
		chk({7'h00, busy}, 8'h01);
		wcmd('{`SFE_OP_RDSTAT});
		mem_m.delete();
		chk({7'h00, standby}, 8'h01);
		a = $random(seed) & 32'h1fff;
		rdchk(a, 3);
		$display("test full clear done");
		// Offset near the page end so the data wraps within the page
		a = ($random(seed) & 32'h0f00) | 32'hfd;
		repeat (4) d.push_back(8'($random(seed)));
		prog(a, d);
		rdchk(a, 3);
		rdchk(a & 32'h1f00, 2);
		prog(a, '{8'($random(seed))});
		rdchk(a, 1);
		$display("test page write done");
		ctl = 4'hc;
		wreg(`SFE_H_CTRL, {4'h0, ctl});
		rreg(`SFE_H_CTRL, s);
		chk(s, 8'h0c);
		rdchk(a, 3);
		ctl = 4'h4;
		wreg(`SFE_H_CTRL, {4'h0, ctl});
		rdchk(a, 3, 4);
		$display("test modes and pause done");
		wcmd('{`SFE_OP_SECT, 8'h00, a[15:8], 8'h00});
		for (int i = 0; i < 256; i++) mem_m[(a & 32'h1f00) | i] = 8'hff;
		rdchk(a & 32'h1f00, 2);
		rdchk(a, 2);
		$display("test sector clear done");
		wcmd('{`SFE_OP_STW, 8'h04});
		frame('{`SFE_OP_UNLOCK});
		frame('{`SFE_OP_SECT, 8'h00, 8'h1f, 8'h00});
		frame('{`SFE_OP_FULL});
		stat(s);
		chk(s, 8'h06);
		wcmd('{`SFE_OP_STW, 8'h84});
		ctl = 4'h0;
		wreg(`SFE_H_CTRL, {4'h0, ctl});
		wcmd('{`SFE_OP_STW, 8'h00});
		stat(s);
		chk(s, 8'h84);
		ctl = 4'h4;
		wreg(`SFE_H_CTRL, {4'h0, ctl});
		wcmd('{`SFE_OP_STW, 8'h00});
		stat(s);
		chk(s, 8'h00);
		$display("test protection done");
		report_and_stop();
	end
endmodule
